// [spl_map.vh]
// Register offsets, field positions, reset values and timing for the bank
`ifndef SPL_MAP_VH
`define SPL_MAP_VH
`define SPL_OFF_REGULATOR 8'hc1
`define SPL_OFF_SRC_VID 8'hc2
`define SPL_OFF_PWR_LIGHT 8'hc3
`define SPL_OFF_SLEEP 8'hc4
`define SPL_OFF_INVALID_HOST 8'hc6
`define SPL_BIT_REG_OFF 6
`define SPL_BIT_HOST_CLK_PD 7
`define SPL_BIT_CORE_CLK_PD 6
`define SPL_BIT_LIGHT_HI 5
`define SPL_BIT_LIGHT_LO 4
`define SPL_BIT_DEBUG_OUT 3
`define SPL_BIT_PLL_PD 2
`define SPL_BIT_PM_HI 1
`define SPL_BIT_PM_LO 0
`define SPL_BIT_FWD_HI 6
`define SPL_BIT_FWD_LO 4
`define SPL_RST_REGULATOR 8'h00
`define SPL_RST_SRC_VID 8'h00
`define SPL_RST_PWR_LIGHT 8'h00
`define SPL_RST_SLEEP 8'h50
`define SPL_RST_FWD 3'h0
`define SPL_PM_NORMAL 2'h0
`define SPL_PM_ENERGY 2'h1
`define SPL_PM_SOFT_DOWN 2'h2
`define SPL_PM_SAVING 2'h3
`define SPL_LIGHT_LA_SPEED 2'h0
`define SPL_LIGHT_L_A 2'h1
`define SPL_LIGHT_LA_DUPLEX 2'h2
`define SPL_LIGHT_L_DUPLEX 2'h3
`define SPL_STRAP_WAIT 2'h2
`define SPL_SLEEP_UNIT_MS 20
`define SPL_CLK_KHZ 10000
`define SPL_SLEEP_UNIT_CYC (`SPL_SLEEP_UNIT_MS * `SPL_CLK_KHZ)
`endif

// [spl_config_regs.v]
// Power, indicator and VLAN configuration register bank
`timescale 1ns/10ps
`include "spl_map.vh"
module spl_config_regs #(
  parameter SLEEP_UNIT_CYC = `SPL_SLEEP_UNIT_CYC
) (
  input wire core_clk,
  input wire rst_b,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  input wire port2_indicator1_strap,
  input wire port2_indicator0_strap,
  input wire energy_present,
  input wire energy_stretched,
  input wire device_ready,
  input wire link_up,
  input wire activity,
  input wire speed_100,
  input wire full_duplex,
  output reg regulator_off,
  output reg [5:0] source_vid_insert,
  output reg host_clk_pd_en,
  output reg core_clk_pd_en,
  output reg pll_pd_en,
  output reg [1:0] power_mode,
  output reg low_power,
  output reg [2:0] invalid_vid_forward_ports,
  output reg [1:0] host_if_mode,
  output reg indicator_out_0,
  output reg indicator_out_1
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] regulator_control_reg;
  reg [7:0] source_vid_insert_control_reg;
  reg [7:0] power_and_light_control_reg;
  reg [7:0] sleep_delay_reg;
  reg [2:0] fwd_ports_reg;
  reg [1:0] host_mode_reg;
  reg strap_done_reg;
  reg [1:0] strap_wait_reg;
  reg [1:0] strap_s1_reg;
  reg [1:0] strap_s2_reg;
  reg [2:0] in_s1_reg;
  reg [2:0] in_s2_reg;
  reg [31:0] unit_cnt_reg;
  reg [7:0] units_reg;
  reg [7:0] rd_next;
  reg ind0_next;
  reg ind1_next;
  wire no_energy;
  wire sleep_hit;
  wire la;
  assign no_energy = ~in_s2_reg[0];
  assign sleep_hit = (units_reg >= sleep_delay_reg);
  assign la = link_up & ~activity;

  // ----------------------------------------
  // Input synchronisers and strap capture
  // ----------------------------------------
  // Straps are sampled only after reset release, never under async reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
      in_s1_reg <= 3'h0;
      in_s2_reg <= 3'h0;
    end else begin
      strap_s1_reg <= {port2_indicator1_strap, port2_indicator0_strap};
      strap_s2_reg <= strap_s1_reg;
      in_s1_reg <= {device_ready, energy_stretched, energy_present};
      in_s2_reg <= in_s1_reg;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Reserved bits are kept at default, writes only touch defined fields
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_control_reg <= `SPL_RST_REGULATOR;
      source_vid_insert_control_reg <= `SPL_RST_SRC_VID;
      power_and_light_control_reg <= `SPL_RST_PWR_LIGHT;
      sleep_delay_reg <= `SPL_RST_SLEEP;
      fwd_ports_reg <= `SPL_RST_FWD;
      host_mode_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else begin
      // Load only once the synchroniser holds the pins, not its reset zeros
      if (!strap_done_reg) begin
        if (strap_wait_reg == `SPL_STRAP_WAIT) begin
          host_mode_reg <= strap_s2_reg;
          strap_done_reg <= 1'b1;
        end else begin
          strap_wait_reg <= strap_wait_reg + 2'h1;
        end
      end
      if (wr_en) begin
        case (addr)
          `SPL_OFF_REGULATOR: begin
            regulator_control_reg[`SPL_BIT_REG_OFF] <=
              wr_data[`SPL_BIT_REG_OFF];
          end
          `SPL_OFF_SRC_VID: begin
            source_vid_insert_control_reg[5:0] <= wr_data[5:0];
          end
          `SPL_OFF_PWR_LIGHT: begin
            power_and_light_control_reg <= wr_data;
          end
          `SPL_OFF_SLEEP: begin
            sleep_delay_reg <= wr_data;
          end
          `SPL_OFF_INVALID_HOST: begin
            fwd_ports_reg <= wr_data[`SPL_BIT_FWD_HI:`SPL_BIT_FWD_LO];
            if (strap_done_reg) begin
              host_mode_reg <= wr_data[1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    case (addr)
      `SPL_OFF_REGULATOR: rd_next = regulator_control_reg;
      `SPL_OFF_SRC_VID: rd_next = source_vid_insert_control_reg;
      `SPL_OFF_PWR_LIGHT: rd_next = power_and_light_control_reg;
      `SPL_OFF_SLEEP: rd_next = sleep_delay_reg;
      `SPL_OFF_INVALID_HOST: rd_next = {1'b0, fwd_ports_reg, 2'h0,
        host_mode_reg};
      default: rd_next = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Energy-detect sleep timer
  // ----------------------------------------
  // Energy on energy_present restarts the count: the quiet period must be consecutive
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_cnt_reg <= 32'h0;
      units_reg <= 8'h00;
    end else if (power_mode != `SPL_PM_ENERGY || !no_energy) begin
      unit_cnt_reg <= 32'h0;
      units_reg <= 8'h00;
    end else if (!sleep_hit) begin
      if (unit_cnt_reg >= SLEEP_UNIT_CYC - 1) begin
        unit_cnt_reg <= 32'h0;
        units_reg <= units_reg + 8'h01;
      end else begin
        unit_cnt_reg <= unit_cnt_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Indicator mapping
  // ----------------------------------------
  always @* begin
    case (power_and_light_control_reg[`SPL_BIT_LIGHT_HI:`SPL_BIT_LIGHT_LO])
      `SPL_LIGHT_LA_SPEED: begin
        ind0_next = la;
        ind1_next = speed_100;
      end
      `SPL_LIGHT_L_A: begin
        ind0_next = link_up;
        ind1_next = activity;
      end
      `SPL_LIGHT_LA_DUPLEX: begin
        ind0_next = la;
        ind1_next = full_duplex;
      end
      default: begin
        ind0_next = link_up;
        ind1_next = full_duplex;
      end
    endcase
    if (power_and_light_control_reg[`SPL_BIT_DEBUG_OUT]) begin
      ind0_next = ~in_s2_reg[2];
      ind1_next = ~in_s2_reg[1];
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      regulator_off <= 1'b0;
      source_vid_insert <= 6'h00;
      host_clk_pd_en <= 1'b0;
      core_clk_pd_en <= 1'b0;
      pll_pd_en <= 1'b0;
      power_mode <= `SPL_PM_NORMAL;
      low_power <= 1'b0;
      invalid_vid_forward_ports <= 3'h0;
      host_if_mode <= 2'h0;
      indicator_out_0 <= 1'b0;
      indicator_out_1 <= 1'b0;
    end else begin
      rd_data <= rd_en ? rd_next : 8'h00;
      regulator_off <= regulator_control_reg[`SPL_BIT_REG_OFF];
      source_vid_insert <= source_vid_insert_control_reg[5:0];
      host_clk_pd_en <=
        power_and_light_control_reg[`SPL_BIT_HOST_CLK_PD];
      core_clk_pd_en <=
        power_and_light_control_reg[`SPL_BIT_CORE_CLK_PD];
      pll_pd_en <= power_and_light_control_reg[`SPL_BIT_PLL_PD];
      power_mode <= power_and_light_control_reg[1:0];
      low_power <= (power_mode == `SPL_PM_ENERGY) && no_energy && sleep_hit;
      invalid_vid_forward_ports <= fwd_ports_reg;
      host_if_mode <= host_mode_reg;
      indicator_out_0 <= ind0_next;
      indicator_out_1 <= ind1_next;
    end
  end
endmodule // spl_config_regs

// [spl_config_assertions.sv]
// Checker for the configuration register bank
`timescale 1ns/10ps
module spl_config_assertions (
  input wire core_clk,
  input wire rst_b,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire regulator_off,
  input wire [5:0] source_vid_insert,
  input wire host_clk_pd_en,
  input wire core_clk_pd_en,
  input wire pll_pd_en,
  input wire [1:0] power_mode,
  input wire [2:0] invalid_vid_forward_ports
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Fields reach their outputs two edges after the write
  reg_off_a: assert property (wr_en && addr == 8'hc1 |-> ##2
    regulator_off == $past(wr_data[6], 2)) else $error("regulator off");
  vid_ins_a: assert property (wr_en && addr == 8'hc2 |-> ##2
    source_vid_insert == $past(wr_data[5:0], 2)) else $error("vid insert");
  host_pd_a: assert property (wr_en && addr == 8'hc3 |-> ##2
    host_clk_pd_en == $past(wr_data[7], 2)) else $error("host pd");
  core_pd_a: assert property (wr_en && addr == 8'hc3 |-> ##2
    core_clk_pd_en == $past(wr_data[6], 2)) else $error("core pd");
  pll_pd_a: assert property (wr_en && addr == 8'hc3 |-> ##2
    pll_pd_en == $past(wr_data[2], 2)) else $error("pll pd");
  pm_sel_a: assert property (wr_en && addr == 8'hc3 |-> ##2
    power_mode == $past(wr_data[1:0], 2)) else $error("power mode");
  fwd_ports_a: assert property (wr_en && addr == 8'hc6 |-> ##2
    invalid_vid_forward_ports == $past(wr_data[6:4], 2))
    else $error("forward ports");
  unmap_rd_a: assert property (rd_en && addr == 8'hc5 |=>
    rd_data == 8'h00) else $error("unmapped read");
endmodule // spl_config_assertions

bind spl_config_regs spl_config_assertions chk (.*);

// [testbench.sv]
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module testbench;
  reg core_clk = 0, rst_b = 0, wr_en = 0, rd_en = 0;
  reg [7:0] addr = 0, wr_data = 0;
  reg s1 = 1, s0 = 0, ep = 1, es = 0, dr = 1, lu = 1, ac = 1, sp = 1, fd = 0;
  wire [7:0] rd_data;
  wire ro, hc, cc, pl, lp, o0, o1;
  wire [5:0] sv;
  wire [1:0] pm, hm;
  wire [2:0] fw;
  integer failures = 0, checked = 0, i;
  reg [23:0] rows [0:5];
  spl_config_regs #(.SLEEP_UNIT_CYC(4)) uut (.core_clk(core_clk),
    .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .port2_indicator1_strap(s1),
    .port2_indicator0_strap(s0), .energy_present(ep),
    .energy_stretched(es), .device_ready(dr), .link_up(lu),
    .activity(ac), .speed_100(sp), .full_duplex(fd), .regulator_off(ro),
    .source_vid_insert(sv), .host_clk_pd_en(hc), .core_clk_pd_en(cc),
    .pll_pd_en(pl), .power_mode(pm), .low_power(lp),
    .invalid_vid_forward_ports(fw), .host_if_mode(hm),
    .indicator_out_0(o0), .indicator_out_1(o1));
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      wr_en <= 1;
      addr <= a;
      wr_data <= d;
      @(posedge core_clk);
      wr_en <= 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge core_clk);
      rd_en <= 1;
      addr <= a;
      @(posedge core_clk);
      rd_en <= 0;
      #1 chk("read", e, rd_data);
    end
  endtask
  task end_sim;
    begin
      if (failures == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial forever #50 core_clk = ~core_clk;
  initial begin
    rows[0] = 24'hc14040;
    rows[1] = 24'hc23f3f;
    rows[2] = 24'hc3a5a5;
    rows[3] = 24'hc40707;
    rows[4] = 24'hc67373;
    rows[5] = 24'hc5ff00;
    wt(10);
    rst_b <= 1;
    wt(6);
    rd(8'hc1, 8'h00);
    rd(8'hc3, 8'h00);
    rd(8'hc4, 8'h50);
    rd(8'hc6, 8'h02);
    // Reserved bits written back at their defaults
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk("regoff", 8'h01, ro);
    chk("vidins", 8'h3f, sv);
    chk("clkpd", 8'h02, {hc, cc});
    chk("pllpd", 8'h01, pl);
    chk("pmode", 8'h01, pm);
    chk("fwd", 8'h07, fw);
    chk("host", 8'h03, hm);
    // Inputs chosen so each light mode gives a distinct pair
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hc3, {2'h0, i[1:0], 4'h0});
      wt(3);
      chk("light", (8'h4e >> (2 * i)) & 8'h03, {o1, o0});
    end
    wr(8'hc3, 8'h18);
    wt(5);
    chk("debug", 8'h02, {o1, o0});
    wr(8'hc4, 8'h02);
    wr(8'hc3, 8'h01);
    ep <= 0;
    wt(4);
    chk("early", 8'h00, lp);
    for (i = 0; i < 40 && lp !== 1'b1; i = i + 1)
      wt(1);
    chk("sleep", 8'h01, lp);
    if (lp !== 1'b1)
      end_sim;
    ep <= 1;
    wt(4);
    chk("wake", 8'h00, lp);
    rst_b <= 0;
    wt(2);
    chk("inrst", 8'h00, {hc, cc, pl, ro, lp, fw});
    rst_b <= 1;
    wt(6);
    rd(8'hc3, 8'h00);
    rd(8'hc4, 8'h50);
    rd(8'hc6, 8'h02);
    end_sim;
  end
endmodule // testbench
